// ==== rtufm_pkg.sv ====
package rtufm_pkg;
  localparam int CLK_MHZ = 200;
  localparam int T3_US_2400 = 15000;
  localparam int T3_US_4800 = 10000;
  localparam int T3_US_9600 = 5000;
  localparam int T3_CYC_2400 = T3_US_2400 * CLK_MHZ;
  localparam int T3_CYC_4800 = T3_US_4800 * CLK_MHZ;
  localparam int T3_CYC_9600 = T3_US_9600 * CLK_MHZ;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
  localparam int TICKS_PER_S = 1000 / TICK_MS;
  localparam logic [3:0] TXERR_LIMIT = 4'h8;
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
  localparam logic [7:0] ERR_FC = 8'h01;
  localparam logic [7:0] ERR_ADDR = 8'h02;
  localparam logic [7:0] ERR_DATA = 8'h03;
  localparam logic [7:0] ERR_NAK = 8'h07;
  localparam logic [7:0] ERR_CRC = 8'h47;
  localparam logic [7:0] ERR_PARITY = 8'h48;
  localparam logic [7:0] ERR_OTHER = 8'h49;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TIMING = 8'h04;
  localparam logic [7:0] REG_STATION = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_CLEAR = 8'h10;
  localparam int CTRL_BAUD_LSB = 0;
  localparam int CTRL_ACT_LSB = 2;
  localparam int CTRL_RUN_BIT = 4;
  localparam int CTRL_CMD_BIT = 5;
  localparam int TIM_DELAY_LSB = 0;
  localparam int TIM_DISC_LSB = 16;
  localparam int STAT_CODE_LSB = 0;
  localparam int STAT_CNT_LSB = 8;
  localparam int STAT_CE_BIT = 16;
  localparam int STAT_DISC_BIT = 17;
  localparam int STAT_STOP_BIT = 18;
  localparam int STAT_TRIP_BIT = 19;
  localparam int STAT_HOLD_BIT = 20;
  localparam logic [1:0] RST_BAUD = 2'h2;
  localparam logic [1:0] RST_ACT = 2'h0;
  localparam logic [9:0] RST_DELAY = 10'h000;
  localparam logic [5:0] RST_DISC = 6'h00;
  localparam logic [7:0] RST_STATION = 8'h01;
  localparam logic [1:0] ACT_STOP = 2'h0;
  localparam logic [1:0] ACT_DELAY_STOP = 2'h1;
  localparam logic [1:0] ACT_DELAY_TRIP = 2'h2;
  localparam logic [1:0] ACT_CONTINUE = 2'h3;

  typedef enum logic [1:0] {
    ST_SYNC = 2'b00,
    ST_IDLE = 2'b01,
    ST_RECV = 2'b10,
    ST_RESP = 2'b11
  } rtufm_state_t;

  typedef enum logic [1:0] {
    TX_DATA = 2'b00,
    TX_CRCLO = 2'b01,
    TX_CRCHI = 2'b10,
    TX_DONE = 2'b11
  } rtufm_txph_t;

  typedef struct packed {
    logic [7:0] data;
    logic parity_err;
    logic frame_err;
    logic overrun_err;
  } rtufm_rxch_t;

  typedef struct packed {
    logic good;
    logic bcast;
    logic addressed;
    logic trans_err;
    logic [7:0] code;
  } rtufm_frm_t;
endpackage : rtufm_pkg

// ==== rtufm_crc.sv ====
`timescale 1ns/1ps
module rtufm_crc import rtufm_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Byte stream
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  // Running check value
  output logic [15:0] crc
);
  function automatic logic [15:0] rtufm_crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction : rtufm_crc_byte

  logic [15:0] crc_reg;
  logic [15:0] crc_next;
  wire [15:0] crc_base = init ? CRC_INIT : crc_reg;

  assign crc_next = en ? rtufm_crc_byte(crc_base, data) : crc_base;
  assign crc = crc_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) crc_reg <= CRC_INIT;
    else crc_reg <= crc_next;
  end

  property p_crc_first;
    @(posedge clk_sys) disable iff (!resetn)
    init && en && data == 8'h01 |=> crc == 16'h807e;
  endproperty
  a_crc_first: assert property (p_crc_first) else $error("crc first byte step wrong");
endmodule : rtufm_crc

// ==== rtufm_top.sv ====
`timescale 1ns/1ps
module rtufm_top import rtufm_pkg::*; #(
  parameter int T3_2400_CYC = T3_CYC_2400,
  parameter int T3_4800_CYC = T3_CYC_4800,
  parameter int T3_9600_CYC = T3_CYC_9600,
  parameter int TICK_LEN_CYC = TICK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Received characters from the serial receiver
  input wire logic rx_valid,
  input wire rtufm_rxch_t rx_char,
  // Frame bytes to the query decoder
  output logic rxo_valid,
  output logic [7:0] rxo_data,
  output logic rxo_first,
  // Frame verdict
  output logic frm_done,
  output rtufm_frm_t frm,
  output logic resp_allow,
  // Logical error report from the decoder
  input wire logic lerr_valid,
  input wire logic [7:0] lerr_code,
  // Response bytes in
  input wire logic tx_in_valid,
  input wire logic [7:0] tx_in_data,
  input wire logic tx_in_last,
  output logic tx_in_ready,
  // Bytes to the serial transmitter
  output logic tx_out_valid,
  output logic [7:0] tx_out_data,
  input wire logic tx_out_ready,
  // Error actions
  output logic comm_err,
  output logic disconnected,
  output logic stop_force,
  output logic trip,
  output logic hold_cmd
);
  rtufm_state_t st_reg, st_next;
  rtufm_txph_t ph_reg, ph_next;
  logic [23:0] gap_reg;
  logic [24:0] pre_reg;
  logic tick_reg;
  logic [1:0] baud_reg, act_reg;
  logic run_reg, cmd_reg;
  logic [9:0] delay_reg;
  logic [5:0] disc_time_reg;
  logic [7:0] station_reg, addr_reg, code_reg;
  logic perr_reg, oerr_reg, seen_reg, fired_reg;
  logic [3:0] cnt_reg;
  logic [9:0] disc_cnt_reg, act_cnt_reg;
  logic act_run_reg;
  logic [15:0] crc_rx, crc_tx;
  logic txv_next;
  logic [7:0] txd_next;
  logic [31:0] rd_mux;
  logic comm_err_reg, disc_reg, stop_reg, trip_reg, hold_reg;
  logic rxo_valid_reg, rxo_first_reg, frm_done_reg, resp_allow_reg;
  logic [7:0] rxo_data_reg, tx_out_data_reg;
  logic tx_in_ready_reg, tx_out_valid_reg;
  logic [31:0] reg_rdata_reg;
  rtufm_frm_t frm_reg;

  // Register decode
  wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  wire wr_timing = reg_wr && (reg_addr == REG_TIMING);
  wire wr_station = reg_wr && (reg_addr == REG_STATION);
  wire wr_clear = reg_wr && (reg_addr == REG_CLEAR) && reg_wdata[0];

  wire [23:0] t3_cyc = (baud_reg == 2'h0) ? 24'(T3_2400_CYC) :
                       (baud_reg == 2'h1) ? 24'(T3_4800_CYC) : 24'(T3_9600_CYC);
  wire gap_hit = (gap_reg >= t3_cyc);
  wire in_frame = (st_reg == ST_IDLE) || (st_reg == ST_RECV);
  wire take_char = rx_valid && in_frame;

  wire close = (st_reg == ST_RECV) && gap_hit && !rx_valid;
  wire addressed = (addr_reg == station_reg);
  wire bcast = (addr_reg == ADDR_BCAST);
  wire crc_ok = (crc_rx == 16'h0000);
  wire chr_err = perr_reg || oerr_reg;
  wire good = close && !chr_err && crc_ok;
  wire trans_evt = close && (chr_err || (!crc_ok && addressed));
  wire [7:0] trans_code = perr_reg ? ERR_PARITY : (oerr_reg ? ERR_OTHER : ERR_CRC);
  wire resp_ok = good && addressed && !bcast;
  wire ce_cnt = trans_evt && (cnt_reg == TXERR_LIMIT - 4'h1);

  wire disc_cond = run_reg && cmd_reg && seen_reg && !good;
  wire [9:0] disc_target = {4'h0, disc_time_reg} * 10'(TICKS_PER_S);
  wire disc_fire = disc_cond && (disc_time_reg != 6'h00) && !fired_reg &&
                   (disc_cnt_reg == disc_target);
  wire ce_evt = ce_cnt || disc_fire;
  wire act_exp = act_run_reg && (act_cnt_reg >= delay_reg);

  wire stop_set = (ce_evt && (act_reg == ACT_STOP)) ||
                  (act_exp && (act_reg == ACT_DELAY_STOP));
  wire trip_set = act_exp && (act_reg == ACT_DELAY_TRIP) && comm_err_reg && !good;

  // Transmit handshake terms
  wire tx_take = tx_in_valid && tx_in_ready_reg;
  wire out_free = !tx_out_valid_reg || tx_out_ready;

  rtufm_crc u_crc_rx (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .init(st_reg == ST_IDLE),
    .en(take_char),
    .data(rx_char.data),
    .crc(crc_rx)
  );

  rtufm_crc u_crc_tx (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .init(st_reg != ST_RESP),
    .en(tx_take),
    .data(tx_in_data),
    .crc(crc_tx)
  );

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_SYNC: if (gap_hit && !rx_valid) st_next = ST_IDLE;
      ST_IDLE: if (rx_valid) st_next = ST_RECV;
      ST_RECV: if (close) st_next = resp_ok ? ST_RESP : ST_IDLE;
      ST_RESP: if (ph_reg == TX_DONE && out_free) st_next = ST_IDLE;
      default: st_next = ST_SYNC;
    endcase
  end

  always_comb begin
    ph_next = ph_reg;
    txv_next = tx_out_valid_reg;
    txd_next = tx_out_data_reg;
    if (st_reg != ST_RESP) begin
      ph_next = TX_DATA;
      txv_next = 1'b0;
    end else if (tx_take) begin
      txv_next = 1'b1;
      txd_next = tx_in_data;
      if (tx_in_last) ph_next = TX_CRCLO;
    end else if (out_free) begin
      case (ph_reg)
        TX_CRCLO: begin
          txv_next = 1'b1;
          txd_next = crc_tx[7:0];
          ph_next = TX_CRCHI;
        end
        TX_CRCHI: begin
          txv_next = 1'b1;
          txd_next = crc_tx[15:8];
          ph_next = TX_DONE;
        end
        default: txv_next = 1'b0;
      endcase
    end
  end

  // Read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      REG_CTRL: begin
        rd_mux[CTRL_BAUD_LSB +: 2] = baud_reg;
        rd_mux[CTRL_ACT_LSB +: 2] = act_reg;
        rd_mux[CTRL_RUN_BIT] = run_reg;
        rd_mux[CTRL_CMD_BIT] = cmd_reg;
      end
      REG_TIMING: begin
        rd_mux[TIM_DELAY_LSB +: 10] = delay_reg;
        rd_mux[TIM_DISC_LSB +: 6] = disc_time_reg;
      end
      REG_STATION: rd_mux[7:0] = station_reg;
      REG_STATUS: begin
        rd_mux[STAT_CODE_LSB +: 8] = code_reg;
        rd_mux[STAT_CNT_LSB +: 4] = cnt_reg;
        rd_mux[STAT_CE_BIT] = comm_err_reg;
        rd_mux[STAT_DISC_BIT] = disc_reg;
        rd_mux[STAT_STOP_BIT] = stop_reg;
        rd_mux[STAT_TRIP_BIT] = trip_reg;
        rd_mux[STAT_HOLD_BIT] = hold_reg;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Software registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      baud_reg <= RST_BAUD;
      act_reg <= RST_ACT;
      run_reg <= 1'b0;
      cmd_reg <= 1'b0;
      delay_reg <= RST_DELAY;
      disc_time_reg <= RST_DISC;
      station_reg <= RST_STATION;
      reg_rdata_reg <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        baud_reg <= reg_wdata[CTRL_BAUD_LSB +: 2];
        act_reg <= reg_wdata[CTRL_ACT_LSB +: 2];
        run_reg <= reg_wdata[CTRL_RUN_BIT];
        cmd_reg <= reg_wdata[CTRL_CMD_BIT];
      end
      if (wr_timing) begin
        delay_reg <= reg_wdata[TIM_DELAY_LSB +: 10];
        disc_time_reg <= reg_wdata[TIM_DISC_LSB +: 6];
      end
      if (wr_station) station_reg <= reg_wdata[7:0];
      reg_rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Framing, gap and tick timers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= ST_SYNC;
      gap_reg <= 24'h00_0000;
      pre_reg <= 25'h000_0000;
      tick_reg <= 1'b0;
      addr_reg <= 8'h00;
      perr_reg <= 1'b0;
      oerr_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (rx_valid) gap_reg <= 24'h00_0000;
      else if (!gap_hit) gap_reg <= gap_reg + 24'h00_0001;
      tick_reg <= (pre_reg == 25'(TICK_LEN_CYC - 1));
      pre_reg <= (pre_reg == 25'(TICK_LEN_CYC - 1)) ? 25'h000_0000 : pre_reg + 25'h000_0001;
      if (take_char && st_reg == ST_IDLE) begin
        addr_reg <= rx_char.data;
        perr_reg <= rx_char.parity_err;
        oerr_reg <= rx_char.frame_err || rx_char.overrun_err;
      end else if (take_char) begin
        perr_reg <= perr_reg || rx_char.parity_err;
        oerr_reg <= oerr_reg || rx_char.frame_err || rx_char.overrun_err;
      end
    end
  end

  // Error counting and disconnection
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 4'h0;
      code_reg <= 8'h00;
      seen_reg <= 1'b0;
      fired_reg <= 1'b0;
      disc_cnt_reg <= 10'h000;
      disc_reg <= 1'b0;
    end else begin
      if (good) cnt_reg <= 4'h0;
      else if (trans_evt && cnt_reg != TXERR_LIMIT) cnt_reg <= cnt_reg + 4'h1;
      if (trans_evt) code_reg <= trans_code;
      else if (lerr_valid) code_reg <= lerr_code;
      if (good) seen_reg <= 1'b1;
      if (!disc_cond) disc_cnt_reg <= 10'h000;
      else if (tick_reg && disc_cnt_reg != disc_target) disc_cnt_reg <= disc_cnt_reg + 10'h001;
      fired_reg <= disc_cond && (fired_reg || disc_fire);
      disc_reg <= disc_cond;
    end
  end

  // Error actions
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      comm_err_reg <= 1'b0;
      act_run_reg <= 1'b0;
      act_cnt_reg <= 10'h000;
      stop_reg <= 1'b0;
      trip_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      comm_err_reg <= ce_evt || (comm_err_reg && !good);
      if (ce_evt) begin
        act_run_reg <= (act_reg == ACT_DELAY_STOP) || (act_reg == ACT_DELAY_TRIP);
        act_cnt_reg <= 10'h000;
      end else begin
        if (act_exp || (good && act_reg == ACT_DELAY_TRIP)) act_run_reg <= 1'b0;
        if (act_run_reg && tick_reg) act_cnt_reg <= act_cnt_reg + 10'h001;
      end
      stop_reg <= stop_set || (stop_reg && !wr_clear);
      trip_reg <= trip_set || (trip_reg && !wr_clear);
      hold_reg <= (ce_evt && act_reg != ACT_STOP) || (hold_reg && !good);
    end
  end

  // Output stage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ph_reg <= TX_DATA;
      rxo_valid_reg <= 1'b0;
      rxo_data_reg <= 8'h00;
      rxo_first_reg <= 1'b0;
      frm_done_reg <= 1'b0;
      frm_reg <= '0;
      resp_allow_reg <= 1'b0;
      tx_in_ready_reg <= 1'b0;
      tx_out_valid_reg <= 1'b0;
      tx_out_data_reg <= 8'h00;
    end else begin
      ph_reg <= ph_next;
      rxo_valid_reg <= take_char;
      rxo_data_reg <= rx_char.data;
      rxo_first_reg <= take_char && (st_reg == ST_IDLE);
      frm_done_reg <= close;
      frm_reg <= '{good: good, bcast: bcast, addressed: addressed,
                   trans_err: trans_evt, code: trans_code};
      resp_allow_reg <= (st_next == ST_RESP);
      tx_in_ready_reg <= (st_next == ST_RESP) && (ph_next == TX_DATA) && !tx_take && out_free;
      tx_out_valid_reg <= txv_next;
      tx_out_data_reg <= txd_next;
    end
  end

  assign reg_rdata = reg_rdata_reg;
  assign rxo_valid = rxo_valid_reg;
  assign rxo_data = rxo_data_reg;
  assign rxo_first = rxo_first_reg;
  assign frm_done = frm_done_reg;
  assign frm = frm_reg;
  assign resp_allow = resp_allow_reg;
  assign tx_in_ready = tx_in_ready_reg;
  assign tx_out_valid = tx_out_valid_reg;
  assign tx_out_data = tx_out_data_reg;
  assign comm_err = comm_err_reg;
  assign disconnected = disc_reg;
  assign stop_force = stop_reg;
  assign trip = trip_reg;
  assign hold_cmd = hold_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_close;
    (st_reg == ST_RECV) && !rx_valid ##1
      (st_reg == ST_RECV) && !rx_valid && gap_hit |=> frm_done_reg;
  endproperty
  a_close: assert property (p_close) else $error("frame not closed on gap");
  property p_no_resp_bad;
    frm_done_reg && !frm_reg.good |-> !resp_allow_reg;
  endproperty
  a_no_resp_bad: assert property (p_no_resp_bad) else $error("reply opened for bad frame");
  property p_bcast;
    frm_done_reg && frm_reg.bcast |-> !resp_allow_reg;
  endproperty
  a_bcast: assert property (p_bcast) else $error("reply opened for broadcast");
  property p_cnt_clear;
    frm_done_reg && frm_reg.good |-> cnt_reg == 4'h0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("count not cleared");
  property p_eight;
    trans_evt && cnt_reg == 4'h7 |=> comm_err_reg && cnt_reg == 4'h8;
  endproperty
  a_eight: assert property (p_eight) else $error("eighth error not raised");
  property p_disc_clr;
    !disc_cond |=> disc_cnt_reg == 10'h000;
  endproperty
  a_disc_clr: assert property (p_disc_clr) else $error("disconnect timer not clear");
  property p_disc_fire;
    disc_fire |=> comm_err_reg;
  endproperty
  a_disc_fire: assert property (p_disc_fire) else $error("disconnect error missed");
  property p_stop0;
    ce_evt && act_reg == ACT_STOP |=> stop_reg && !hold_reg;
  endproperty
  a_stop0: assert property (p_stop0) else $error("no immediate stop");
  property p_mode1;
    act_exp && act_reg == ACT_DELAY_STOP |=> stop_reg;
  endproperty
  a_mode1: assert property (p_mode1) else $error("no delayed stop");
  property p_mode3;
    ce_evt && act_reg == ACT_CONTINUE && !stop_reg && !trip_reg && !act_run_reg
      |=> !stop_reg && !trip_reg && hold_reg;
  endproperty
  a_mode3: assert property (p_mode3) else $error("continue mode stopped");
  property p_crc_order;
    st_reg == ST_RESP && !tx_take && out_free && ph_reg == TX_CRCLO
      |=> tx_out_valid_reg && tx_out_data_reg == $past(crc_tx[7:0]) && ph_reg == TX_CRCHI;
  endproperty
  a_crc_order: assert property (p_crc_order) else $error("check low byte not first");
  c_reply: cover property (frm_done_reg && frm_reg.good ##1 tx_out_valid_reg);
  c_ce: cover property (ce_cnt);
  c_disc: cover property (disc_fire);
  c_trip: cover property (trip_set);
endmodule : rtufm_top

// ==== rtufm_host.sv ====
`timescale 1ns/1ps
module rtufm_host import rtufm_pkg::*; (
  // Receiver side
  output logic rx_valid,
  output rtufm_rxch_t rx_char,
  // Transmitter side
  input wire logic clk_sys,
  input wire logic tx_out_valid,
  output logic tx_out_ready
);
  initial begin
    rx_valid = 1'b0;
    rx_char = '0;
    tx_out_ready = 1'b0;
  end
  // Transmitter stalls at random
  always @(posedge clk_sys) begin
    tx_out_ready <= 1'(test_rtufm_top.rnd());
  end
  task automatic send(input logic [7:0] q[$], input logic [1:0] ek);
    foreach (q[i]) begin
      repeat (1 + test_rtufm_top.rnd() % 150) @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_char <= '{q[i], ek == 2'h1 && i == 2, ek == 2'h2 && i == 2, 1'b0};
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      // Released line shows no stale byte
      rx_char.data <= ~q[i];
    end
  endtask : send
endmodule : rtufm_host

// ==== test_rtufm_top.sv ====
`timescale 1ns/1ps
module test_rtufm_top import rtufm_pkg::*;;
  localparam int T3 = 200;
  localparam int T3_SLOW = 600;
  localparam int T3_MID = 400;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, lerr_valid = 1'b0, tx_in_valid = 1'b0, tx_in_last = 1'b0;
  logic [7:0] reg_addr = 8'h00, lerr_code = 8'h00, tx_in_data = 8'h00;
  logic [31:0] reg_wdata = 32'h0, seed = 32'h8d93, reg_rdata;
  logic rx_valid, tx_out_ready, rxo_valid, rxo_first, frm_done, resp_allow, tx_in_ready;
  logic tx_out_valid, comm_err, disconnected, stop_force, trip, hold_cmd, rd_d = 1'b0;
  logic [7:0] rxo_data, tx_out_data;
  rtufm_rxch_t rx_char;
  rtufm_frm_t frm;
  int errors = 0, samples_checked = 0, cyc = 0;
  logic [11:0] fq[$];
  logic [63:0] rq[$];
  logic [7:0] tq[$];
  logic [7:0] aq[$];
  int t3w = T3;

  rtufm_top #(.T3_2400_CYC(T3_SLOW), .T3_4800_CYC(T3_MID), .T3_9600_CYC(T3), .TICK_LEN_CYC(50))
  u_rtufm_top (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rx_valid, .rx_char, .rxo_valid, .rxo_data, .rxo_first, .frm_done, .frm, .resp_allow,
    .lerr_valid, .lerr_code, .tx_in_valid, .tx_in_data, .tx_in_last, .tx_in_ready,
    .tx_out_valid, .tx_out_data, .tx_out_ready, .comm_err, .disconnected, .stop_force,
    .trip, .hold_cmd);
  rtufm_host u_rtufm_host (.rx_valid, .rx_char, .clk_sys, .tx_out_valid, .tx_out_ready);

  always #2.5 clk_sys = ~clk_sys;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc16

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // Result watchers
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      chk("reg_rdata", rq[0][31:0], reg_rdata & rq[0][63:32]);
      void'(rq.pop_front());
    end
    if (frm_done) begin
      chk("frm", fq[0] & (fq[0][8] ? 12'hdff : 12'hd00),
          frm & (fq[0][8] ? 12'hdff : 12'hd00));
      void'(fq.pop_front());
    end
    if (rxo_valid && rxo_first) begin
      chk("rxo_data", aq[0], rxo_data);
      void'(aq.pop_front());
    end
    if (tx_out_valid && tx_out_ready) begin
      chk("tx_out_data", tq[0], tx_out_data);
      void'(tq.pop_front());
    end
    cyc++;
    if (cyc == 80000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back({m, e & m});
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic frm_tx(input logic [7:0] a, input logic [1:0] ek, input logic bad,
                        input logic [11:0] ex);
    logic [7:0] q[$];
    logic [15:0] c;
    q = {a, 8'h03, 8'(rnd()), 8'(rnd())};
    c = crc16(q) ^ {15'h0, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    fq.push_back(ex);
    aq.push_back(a);
    u_rtufm_host.send(q, ek);
    repeat (t3w + 8) @(posedge clk_sys);
  endtask : frm_tx

  initial begin
    logic [7:0] lc[4] = '{8'h01, 8'h02, 8'h03, 8'h07};
    logic [7:0] d[$];
    int m;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (T3 + 8) @(posedge clk_sys);
    rd(8'h0c, 32'h0, 32'hffffffff);
    rd(8'h14, 32'h0, 32'hffffffff);
    rd(8'h08, 32'h1, 32'hffffffff);
    foreach (lc[i]) begin
      @(posedge clk_sys);
      lerr_valid <= 1'b1;
      lerr_code <= lc[i];
      @(posedge clk_sys);
      lerr_valid <= 1'b0;
      rd(8'h0c, {24'h0, lc[i]}, 32'hff);
    end
    $display("done: registers and logical codes");
    for (int k = 0; k < 3; k++) begin
      m = k == 2 ? 3 : k;
      t3w = k == 0 ? T3_SLOW : k == 1 ? T3_MID : T3;
      wr(8'h00, 32'h30 | 32'(k) | 32'(m << 2));
      rd(8'h00, 32'h30 | 32'(k) | 32'(m << 2), 32'h3f);
      for (int i = 0; i < 8; i++) begin
        if (i == 7) chk("comm_err", 32'h0, comm_err);
        frm_tx(8'h01, i == 6 ? 2'h1 : i == 7 ? 2'h2 : 2'h0, 1'b1,
               {4'h3, 8'h47 + 8'(i > 5 ? i - 5 : 0)});
      end
      rd(8'h0c, 32'h0001_0849, 32'h0001_0fff);
      chk("stop_force", 32'(m != 3), stop_force);
      chk("hold_cmd", 32'(m != 0), hold_cmd);
      frm_tx(8'h05, 2'h0, 1'b0, 12'h800);
      rd(8'h0c, m != 3 ? 32'h0004_0000 : 32'h0, 32'h0015_0f00);
      wr(8'h10, 32'h1);
      rd(8'h0c, 32'h0, 32'h000c_0000);
      $display("done: error action %0d", m);
    end
    chk("disconnected", 32'h1, disconnected);
    chk("comm_err", 32'h0, comm_err);
    wr(8'h00, 32'h3a);
    wr(8'h04, 32'h0001_0002);
    rd(8'h04, 32'h0001_0002, 32'h003f_03ff);
    repeat (800) @(posedge clk_sys);
    rd(8'h0c, 32'h001b_0000, 32'h001f_0000);
    chk("trip", 32'h1, trip);
    chk("disconnected", 32'h1, disconnected);
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h1);
    @(posedge clk_sys);
    chk("trip", 32'h0, trip);
    $display("done: disconnection and trip");
    frm_tx(8'h00, 2'h0, 1'b0, 12'hc00);
    chk("resp_allow", 32'h0, resp_allow);
    frm_tx(8'h01, 2'h0, 1'b0, 12'ha00);
    chk("resp_allow", 32'h1, resp_allow);
    d = {8'(rnd()), 8'(rnd()), 8'(rnd())};
    foreach (d[i]) begin
      tq.push_back(d[i]);
      @(posedge clk_sys);
      tx_in_valid <= 1'b1;
      tx_in_data <= d[i];
      tx_in_last <= i == 2;
      do @(posedge clk_sys); while (tx_in_ready !== 1'b1);
      tx_in_valid <= 1'b0;
    end
    tq.push_back(8'(crc16(d)));
    tq.push_back(8'(crc16(d) >> 8));
    repeat (400) if (tq.size() != 0) @(posedge clk_sys);
    repeat (T3) @(posedge clk_sys);
    chk("resp_allow", 32'h0, resp_allow);
    chk("queues", 32'h0, 32'(fq.size() + rq.size() + tq.size() + aq.size()));
    $display("done: response and broadcast");
    give_verdict();
  end
endmodule : test_rtufm_top
